// ---- dv/rrm_front_model.sv ----
// far-side model: synthesizer lock and the host's transparent bit stream
// assumes one aclk shared with the mapper; stream feeds both pins
`timescale 1ns/100ps
module rrm_front_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       synth_en,
    input  wire logic       lock_hold,
    output logic            synth_lock,
    output logic            stream,
    output logic [2:0]      phase
);
    logic [2:0] lock_cnt_q;
    logic [7:0] pat_q;
    // lock reported only after settling, and dropped on the edge after synth_en falls
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !synth_en || lock_hold)
            lock_cnt_q <= 3'h0;
        else if (lock_cnt_q != 3'h7)
            lock_cnt_q <= lock_cnt_q + 3'h1;
    end
    assign synth_lock = (lock_cnt_q == 3'h7);
    // host stream, one bit every eight cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase <= 3'h0;
            pat_q <= 8'hB2;
        end
        else
        begin
            phase <= phase + 3'h1;
            if (phase == 3'h7)
                pat_q <= {pat_q[6:0], pat_q[7]};
        end
    end
    assign stream = pat_q[7];
endmodule : rrm_front_model

// ---- dv/testbench.sv ----
// self-checking bench: AXI4-Lite tasks, tx/rx scenarios, verdict
// assumes HALF_BIT_CYC 4 and the fastest baud range, so a half bit is 4 cycles
`timescale 1ns/100ps
`include "rrm_cfg.svh"
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, serial_cs_n, lock_hold;
    logic        synth_lock, stream, synth_en, rf_mod_level, rf_mod_en, tout, tout_en, irq;
    logic [2:0]  phase;
    int          mismatches, n_tests;

    rrm_bit_mapper #(.HALF_BIT_CYC(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .synth_lock(synth_lock), .rf_demod_level(stream), .serial_cs_n(serial_cs_n),
        .serial_in_transparent_in(stream), .synth_en(synth_en),
        .rf_mod_level(rf_mod_level), .rf_mod_en(rf_mod_en),
        .serial_out_transparent_out(tout), .serial_out_transparent_out_en(tout_en),
        .irq(irq));
    rrm_front_model u_front (.aclk(aclk), .aresetn(aresetn), .synth_en(synth_en),
        .lock_hold(lock_hold), .synth_lock(synth_lock), .stream(stream), .phase(phase));

    always #5 aclk = ~aclk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_hit, w_hit, b_hit;
        logic [1:0] resp;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            // settled values that the coming edge will take
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit  = wvalid && wready;
            b_hit  = (bvalid === 1'b1);
            resp   = bresp;
            @(posedge aclk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
        end while (!b_hit);
        bready <= 1'b0;
        check("bresp", 32'(er), 32'(resp));
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
        logic        ar_hit, r_hit;
        logic [31:0] data;
        logic [1:0]  resp;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            r_hit  = (rvalid === 1'b1);
            data   = rdata;
            resp   = rresp;
            @(posedge aclk);
            if (ar_hit)
                arvalid <= 1'b0;
        end while (!r_hit);
        rready <= 1'b0;
        check("rdata", e, data & m);
        check("rresp", 32'(er), 32'(resp));
    endtask : rd

    task automatic wait_hi(input bit use_irq);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (((use_irq ? irq : rf_mod_en) !== 1'b1) && n < 2000);
        check(use_irq ? "irq" : "mod_en", 32'h1, 32'(use_irq ? irq : rf_mod_en));
    endtask : wait_hi

    // samples each half bit near its middle
    task automatic check_byte(input logic [7:0] b, input bit coded);
        logic e;
        repeat (2) @(negedge aclk);
        for (int k = 0; k < 16; k++)
        begin
            e = b[7 - k / 2];
            if (coded && k % 2 == 0)
                e = !e;
            check("mod_level", 32'(e), 32'(rf_mod_level));
            repeat (4) @(negedge aclk);
        end
    endtask : check_byte

    task automatic check_stream(input bit rx);
        repeat (12)
        begin
            @(negedge aclk iff phase == 3'h6);
            check(rx ? "tout" : "mod_level", 32'(stream), 32'(rx ? tout : rf_mod_level));
            if (rx)
                check("tout_en", 32'h1, 32'(tout_en));
        end
    endtask : check_stream

    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        #400000;
        mismatches++;
        results();
    end

    initial
    begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
        rready = 0; awaddr = 5'h00; araddr = 5'h00; wdata = 32'h0; wstrb = 4'hF;
        serial_cs_n = 1; lock_hold = 1; mismatches = 0; n_tests = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RRM_OFF_STATUS, 32'h100, 32'h71F, 2'b00);
        rd(5'h1C, 32'h0, 32'hFFFFFFFF, 2'b10);
        wr(5'h1C, 32'h0, 2'b10);
        wr(`RRM_OFF_CTRL4, 32'h0, 2'b00);
        wr(`RRM_OFF_CTRL5, 32'h0B, 2'b00);
        wr(`RRM_OFF_CTRL6, 32'hDF, 2'b00);
        rd(`RRM_OFF_CTRL5, 32'h0B, 32'h3F, 2'b00);
        rd(`RRM_OFF_CTRL6, 32'hDF, 32'hFF, 2'b00);
        wr(`RRM_OFF_CTRL1, 32'h11, 2'b00);
        rd(`RRM_OFF_STATUS, 32'h200, 32'h700, 2'b00);
        check("synth_en", 32'h1, 32'(synth_en));
        for (int i = 0; i < 17; i++)
            wr(`RRM_OFF_TXDATA, 32'(i), 2'b00);
        rd(`RRM_OFF_STATUS, 32'h10, 32'h1F, 2'b00);
        wr(`RRM_OFF_CTRL4, 32'h0, 2'b00);
        rd(`RRM_OFF_STATUS, 32'h0, 32'h1F, 2'b00);
        wr(`RRM_OFF_TXDATA, 32'hA5, 2'b00);
        wr(`RRM_OFF_TXDATA, 32'h3C, 2'b00);
        rd(`RRM_OFF_STATUS, 32'h2, 32'h1F, 2'b00);
        check("mod_en", 32'h0, 32'(rf_mod_en));
        lock_hold <= 1'b0;
        wait_hi(0);
        check_byte(8'hA5, 0);
        check_byte(8'h3C, 0);
        repeat (8) @(posedge aclk);
        check("mod_en", 32'h0, 32'(rf_mod_en));
        check("irq", 32'h1, 32'(irq));
        rd(`RRM_OFF_STATUS, 32'h0, 32'h1F, 2'b00);
        wr(`RRM_OFF_CTRL1, 32'h01, 2'b00);
        check("irq", 32'h0, 32'(irq));
        wr(`RRM_OFF_TXDATA, 32'h96, 2'b00);
        wait_hi(0);
        check_byte(8'h96, 1);
        for (int lv = 1; lv < 4; lv++)
        begin
            wr(`RRM_OFF_CTRL1, 32'h01 | 32'(lv << 2), 2'b00);
            for (int i = 0; i < 4 * lv + 2; i++)
                wr(`RRM_OFF_TXDATA, 32'(i), 2'b00);
            wait_hi(1);
            rd(`RRM_OFF_STATUS, 32'(4 * lv), 32'h1F, 2'b00);
        end
        wr(`RRM_OFF_CTRL4, 32'h0, 2'b00);
        rd(`RRM_OFF_STATUS, 32'h0, 32'h1F, 2'b00);
        check("irq", 32'h0, 32'(irq));
        for (int p = 0; p < 2; p++)
        begin
            wr(`RRM_OFF_CTRL1, 32'h21 | 32'(p << 4), 2'b00);
            wr(`RRM_OFF_TXDATA, 32'h55, 2'b00);
            rd(`RRM_OFF_STATUS, 32'h0, 32'h1F, 2'b00);
            check_stream(0);
        end
        wr(`RRM_OFF_CTRL1, 32'h23, 2'b00);
        serial_cs_n <= 1'b0;
        repeat (3) @(posedge aclk);
        check_stream(1);
        @(posedge aclk);
        serial_cs_n <= 1'b1;
        repeat (6) @(posedge aclk);
        check("tout_en", 32'h0, 32'(tout_en));
        wr(`RRM_OFF_CTRL1, 32'h03, 2'b00);
        serial_cs_n <= 1'b0;
        repeat (6) @(posedge aclk);
        check("tout_en", 32'h0, 32'(tout_en));
        results();
    end
endmodule : testbench

// ---- rtl/rrm_bit_mapper.sv ----
// transceiver data path: tx start-up, byte serialiser, rx bit mapper
// assumes AXI4-Lite master on aclk; pins asynchronous to aclk
// Contract
// - op bits high=0 low=1 request transmit; device enters transmit.
// - start-up phase with synthesizer on; active only after lock.
// - host byte loads accepted in start-up and active transmit.
// - sending starts automatically with a byte buffered, msb first.
// - pending count up per load, down per sent byte, readable.
// - interrupt when count falls to the selected level.
// - levels are empty, 4, 8 or 12 bytes.
// - control 1/4/5/6 write in operation clears buffer and count.
// - transparent bit disables buffer, modulates from input pin.
// - pattern bit sends buffer bits as nrz levels.
// - coded mode sends 1 as low-to-high, 0 as high-to-low.
// - transparent transmit: pin 1 high level, 0 low level.
// - fsk receive: rising transition stores 1, falling stores 0.
// - ask receive: off-to-on stores 1, on-to-off stores 0.
// - transparent receive drives received level, stores nothing.
// - transparent output only while chip select is low.
// - buffer holds 16 bytes; more overwrites stored ones.
`timescale 1ns/100ps
`include "rrm_cfg.svh"
module rrm_bit_mapper import rrm_pkg::*; #(
    parameter int unsigned HALF_BIT_CYC = `RRM_HALF_BIT_NS / `RRM_CLK_NS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output wire logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output wire logic        wready,
    output wire logic [1:0]  bresp,
    output wire logic        bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output wire logic        arready,
    output wire logic [31:0] rdata,
    output wire logic [1:0]  rresp,
    output wire logic        rvalid,
    input  wire logic        rready,
    input  wire logic        synth_lock,
    input  wire logic        rf_demod_level,
    input  wire logic        serial_cs_n,
    input  wire logic        serial_in_transparent_in,
    output wire logic        synth_en,
    output wire logic        rf_mod_level,
    output wire logic        rf_mod_en,
    output wire logic        serial_out_transparent_out,
    output wire logic        serial_out_transparent_out_en,
    output wire logic        irq
);
    rrm_buf_if bif ();
    rrm_byte_buffer u_buf (.aclk(aclk), .aresetn(aresetn), .bus(bif));

    logic [3:0]  sy1_q, sy2_q;
    logic        lock_s, demod_s, cs_n_s, tmdi_s;
    logic [5:0]  c1_q, c1_d, c5_q, c5_d;
    logic [1:0]  c4_q, c4_d;
    logic [7:0]  c6_q, c6_d;
    rrm_state_e  st_q, st_d;
    logic [15:0] half_q, half_d;
    rrm_byte_t   sh_q, sh_d, rsh_q, rsh_d;
    logic [2:0]  idx_q, idx_d, rbits_q, rbits_d;
    logic        phase_q, phase_d, busy_q, busy_d, first_q, first_d;
    logic        mod_q, mod_d, men_q, men_d, irq_q, irq_d, tout_q;
    logic        awv_q, awv_d, wv_q, wv_d, ws_q, ws_d, bv_q, bv_d, rv_q, rv_d;
    logic [4:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        tick, irq_set, irq_clr, ctl_wr, wr_go;
    logic        tx_req, rx_mode, pat, transp;
    rrm_reg_e    wsel, rsel;

    function automatic rrm_reg_e reg_sel(input logic [4:0] a);
        case (a)
            `RRM_OFF_CTRL1:  return R_C1;
            `RRM_OFF_CTRL4:  return R_C4;
            `RRM_OFF_CTRL5:  return R_C5;
            `RRM_OFF_CTRL6:  return R_C6;
            `RRM_OFF_TXDATA: return R_TX;
            `RRM_OFF_RXDATA: return R_RX;
            `RRM_OFF_STATUS: return R_ST;
            default:         return R_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [15:0] half_len(input logic [1:0] br);
        return 16'(HALF_BIT_CYC << (2'd3 - br));
    endfunction : half_len

    function automatic logic [4:0] thr(input logic [1:0] lv);
        case (lv)
            2'b00:   return `RRM_THR_0;
            2'b01:   return `RRM_THR_4;
            2'b10:   return `RRM_THR_8;
            default: return `RRM_THR_12;
        endcase
    endfunction : thr

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sy1_q <= 4'h2;
            sy2_q <= 4'h2;
        end
        else
        begin
            sy1_q <= {synth_lock, rf_demod_level, serial_cs_n, serial_in_transparent_in};
            sy2_q <= sy1_q;
        end
    end

    assign {lock_s, demod_s, cs_n_s, tmdi_s} = sy2_q;
    assign tx_req  = !c1_q[`RRM_C1_OPH] && c1_q[`RRM_C1_OPL];
    assign rx_mode = c1_q[`RRM_C1_OPH] && c1_q[`RRM_C1_OPL];
    assign pat     = c1_q[`RRM_C1_PAT];
    assign transp  = c1_q[`RRM_C1_TRN];
    assign wr_go   = awv_q && wv_q && !bv_q;
    assign wsel    = reg_sel(awa_q);
    assign rsel    = reg_sel(araddr);

    always_comb
    begin
        {c1_d, c4_d, c5_d, c6_d} = {c1_q, c4_q, c5_q, c6_q};
        st_d = st_q;     half_d = half_q;   sh_d = sh_q;   rsh_d = rsh_q;
        idx_d = idx_q;   rbits_d = rbits_q; phase_d = phase_q;
        busy_d = busy_q; first_d = first_q; mod_d = mod_q;
        awv_d = awv_q;   awa_d = awa_q;     wv_d = wv_q;   wd_d = wd_q;
        ws_d = ws_q;     bv_d = bv_q;       br_d = br_q;
        rv_d = rv_q;     rd_d = rd_q;       rr_d = rr_q;
        tick = 1'b0;     irq_set = 1'b0;    irq_clr = 1'b0; ctl_wr = 1'b0;
        bif.push = 1'b0; bif.pop = 1'b0;    bif.clear = 1'b0;
        bif.wdata = wd_q[7:0];
        if (awvalid && awready)
        begin
            awv_d = 1'b1;
            awa_d = awaddr;
        end
        if (wvalid && wready)
        begin
            wv_d = 1'b1;
            wd_d = wdata;
            ws_d = wstrb[0];
        end
        if (bv_q && bready)
            bv_d = 1'b0;
        if (wr_go)
        begin
            awv_d = 1'b0;
            wv_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = (wsel == R_NONE) ? 2'b10 : 2'b00;
            if (ws_q)
            begin
                case (wsel)
                    R_C1:    c1_d = wd_q[5:0];
                    R_C4:    c4_d = wd_q[1:0];
                    R_C5:    c5_d = wd_q[5:0];
                    R_C6:    c6_d = wd_q[7:0];
                    default: ;
                endcase
                ctl_wr = (wsel == R_C1) || (wsel == R_C4) || (wsel == R_C5)
                         || (wsel == R_C6);
                if (wsel == R_TX && tx_req && st_q != ST_IDLE && !transp)
                begin
                    bif.push = 1'b1;
                    irq_clr  = 1'b1;
                end
            end
        end
        if (rv_q && rready)
            rv_d = 1'b0;
        if (arvalid && arready)
        begin
            rv_d = 1'b1;
            rr_d = (rsel == R_NONE) ? 2'b10 : 2'b00;
            case (rsel)
                R_C1:    rd_d = {26'h0, c1_q};
                R_C4:    rd_d = {30'h0, c4_q};
                R_C5:    rd_d = {26'h0, c5_q};
                R_C6:    rd_d = {24'h0, c6_q};
                R_RX:    rd_d = {24'h0, bif.head};
                R_ST:    rd_d = {21'h0, st_q, busy_q, lock_s, 1'b0, bif.count};
                default: rd_d = 32'h0;
            endcase
            if (rsel == R_RX && rx_mode)
            begin
                bif.pop = 1'b1;
                irq_clr = 1'b1;
            end
        end
        case (st_q)
            ST_IDLE:   if (tx_req) st_d = ST_START;
            ST_START:  if (!tx_req) st_d = ST_IDLE; else if (lock_s) st_d = ST_ACTIVE;
            ST_ACTIVE: if (!tx_req) st_d = ST_IDLE;
            default:   st_d = ST_IDLE;
        endcase
        if ((st_q == ST_ACTIVE && busy_q) || rx_mode)
        begin
            if (half_q == 16'h0)
            begin
                tick   = 1'b1;
                half_d = half_len(c6_q[`RRM_C6_BR+:2]) - 16'h1;
            end
            else
                half_d = half_q - 16'h1;
        end
        if (st_q == ST_ACTIVE)
        begin
            if (transp)
                mod_d = tmdi_s;
            else if (!busy_q)
            begin
                if (bif.count != 5'h00)
                begin
                    sh_d    = bif.head;
                    idx_d   = 3'd7;
                    phase_d = 1'b0;
                    busy_d  = 1'b1;
                    half_d  = half_len(c6_q[`RRM_C6_BR+:2]) - 16'h1;
                    mod_d   = pat ? bif.head[7] : !bif.head[7];
                end
            end
            else if (tick)
            begin
                if (!phase_q)
                begin
                    phase_d = 1'b1;
                    mod_d   = sh_q[7];
                end
                else
                begin
                    phase_d = 1'b0;
                    if (idx_q == 3'd0)
                    begin
                        bif.pop = 1'b1;
                        busy_d  = 1'b0;
                        irq_set = !bif.push && (bif.count - 5'h01 == thr(c1_q[`RRM_C1_IRH-:2]));
                    end
                    else
                    begin
                        sh_d  = {sh_q[6:0], 1'b0};
                        idx_d = idx_q - 3'd1;
                        mod_d = pat ? sh_q[6] : !sh_q[6];
                    end
                end
            end
        end
        if (rx_mode && !transp && tick)
        begin
            if (!phase_q)
            begin
                phase_d = 1'b1;
                first_d = demod_s;
            end
            else
            begin
                phase_d = 1'b0;
                if (demod_s != first_q)
                begin
                    rsh_d   = {rsh_q[6:0], demod_s};
                    rbits_d = rbits_q + 3'd1;
                    if (rbits_q == 3'd7)
                    begin
                        bif.push  = 1'b1;
                        bif.wdata = {rsh_q[6:0], demod_s};
                        irq_set   = !bif.pop && (bif.count + 5'h01 == thr(c1_q[`RRM_C1_IRH-:2]));
                    end
                end
            end
        end
        if (ctl_wr && (c1_q[1:0] != 2'b00))
        begin
            bif.clear = 1'b1;
            busy_d    = 1'b0;
            phase_d   = 1'b0;
            rbits_d   = 3'd0;
            irq_set   = 1'b0;
            irq_clr   = 1'b1;
        end
        men_d = (st_q == ST_ACTIVE) && (transp || busy_d);
        irq_d = irq_set || (irq_q && !irq_clr);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c1_q <= `RRM_CTRL1_RST;  c4_q <= `RRM_CTRL4_RST;
            c5_q <= `RRM_CTRL5_RST;  c6_q <= `RRM_CTRL6_RST;
            st_q <= ST_IDLE;    half_q <= 16'h0;  sh_q <= 8'h00;  rsh_q <= 8'h00;
            idx_q <= 3'd0;      rbits_q <= 3'd0;  phase_q <= 1'b0; busy_q <= 1'b0;
            first_q <= 1'b0;    mod_q <= 1'b0;    men_q <= 1'b0;  irq_q <= 1'b0;
            tout_q <= 1'b0;     awv_q <= 1'b0;    awa_q <= 5'h00; wv_q <= 1'b0;
            wd_q <= 32'h0;      ws_q <= 1'b0;     bv_q <= 1'b0;   br_q <= 2'b00;
            rv_q <= 1'b0;       rd_q <= 32'h0;    rr_q <= 2'b00;
        end
        else
        begin
            {c1_q, c4_q, c5_q, c6_q} <= {c1_d, c4_d, c5_d, c6_d};
            st_q <= st_d;       half_q <= half_d; sh_q <= sh_d;   rsh_q <= rsh_d;
            idx_q <= idx_d;     rbits_q <= rbits_d; phase_q <= phase_d;
            busy_q <= busy_d;   first_q <= first_d; mod_q <= mod_d;
            men_q <= men_d;     irq_q <= irq_d;   tout_q <= demod_s;
            awv_q <= awv_d;     awa_q <= awa_d;   wv_q <= wv_d;   wd_q <= wd_d;
            ws_q <= ws_d;       bv_q <= bv_d;     br_q <= br_d;
            rv_q <= rv_d;       rd_q <= rd_d;     rr_q <= rr_d;
        end
    end

    assign awready    = !awv_q && !bv_q;
    assign wready     = !wv_q && !bv_q;
    assign arready    = !rv_q;
    assign {bvalid, bresp, rvalid, rdata, rresp} = {bv_q, br_q, rv_q, rd_q, rr_q};
    assign synth_en     = (st_q != ST_IDLE) || rx_mode;
    assign rf_mod_level = mod_q;
    assign rf_mod_en    = men_q;
    assign irq          = irq_q;
    // level out only with select low
    assign serial_out_transparent_out    = tout_q;
    assign serial_out_transparent_out_en = rx_mode && transp && !cs_n_s;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    lock_gate_a: assert property (st_q == ST_START && !lock_s |=> st_q != ST_ACTIVE)
        else $error("active entered without lock");
    load_count_a: assert property (bif.push && !bif.pop && !bif.clear
        && bif.count < `RRM_DEPTH |=> bif.count == $past(bif.count) + 5'h01)
        else $error("load did not raise count");
    msb_coded_a: assert property ($rose(busy_q) && !pat |-> mod_q == !sh_q[7])
        else $error("first half not inverse of msb");
    irq_level_a: assert property ($rose(irq_q) && st_q == ST_ACTIVE
        |-> bif.count == thr(c1_q[`RRM_C1_IRH-:2]))
        else $error("interrupt off threshold");
    ctl_clear_a: assert property (bif.clear |=> bif.count == 5'h00 && !busy_q)
        else $error("control write did not clear");
    pin_follow_a: assert property (st_q == ST_ACTIVE && transp
        |=> mod_q == $past(tmdi_s))
        else $error("transparent level not followed");
    nrz_hold_a: assert property (busy_q && pat && tick && !phase_q
        |=> mod_q == $past(mod_q))
        else $error("nrz level moved mid bit");
    empty_stop_a: assert property (st_q == ST_ACTIVE && !transp && !busy_q
        && bif.count == 5'h00 && !bif.push |=> !busy_q && !rf_mod_en)
        else $error("modulation with empty buffer");
    tout_gate_a: assert property (serial_out_transparent_out_en
        |-> !$past(serial_cs_n, 2) && rx_mode && transp)
        else $error("transparent out driven wrongly");

    byte_sent_c: cover property (busy_q ##1 !busy_q);
    irq_rise_c:  cover property ($rose(irq_q));
    rx_store_c:  cover property (rx_mode && bif.push);
endmodule : rrm_bit_mapper

// ---- rtl/rrm_buf_if.sv ----
// carrier between the mapper and its byte buffer
// assumes both ends on the same aclk
`timescale 1ns/100ps
interface rrm_buf_if import rrm_pkg::*; ();
    logic      push;
    rrm_byte_t wdata;
    logic      pop;
    logic      clear;
    rrm_byte_t head;
    logic [4:0] count;
    modport ctl (output push, wdata, pop, clear, input head, count);
    modport mem (input push, wdata, pop, clear, output head, count);
endinterface : rrm_buf_if

// ---- rtl/rrm_byte_buffer.sv ----
// sixteen-byte circular buffer with pending-byte count
// assumes one push and one pop at most per cycle
`timescale 1ns/100ps
`include "rrm_cfg.svh"
module rrm_byte_buffer import rrm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    rrm_buf_if.mem   bus
);
    rrm_byte_t  mem_q [16];
    rrm_byte_t  mem_d [16];
    logic [3:0] wr_q, wr_d, rd_q, rd_d;
    logic [4:0] cnt_q, cnt_d;
    logic       do_pop;
    logic       full;

    always_comb
    begin
        mem_d  = mem_q;
        wr_d   = wr_q;
        rd_d   = rd_q;
        do_pop = bus.pop && (cnt_q != 5'h00);
        full   = (cnt_q == `RRM_DEPTH) && !do_pop;
        cnt_d  = cnt_q;
        if (bus.clear)
        begin
            wr_d  = 4'h0;
            rd_d  = 4'h0;
            cnt_d = 5'h00;
        end
        else
        begin
            if (bus.push)
            begin
                mem_d[wr_q] = bus.wdata;
                wr_d        = wr_q + 4'h1;
            end
            if (do_pop || (bus.push && full))
                rd_d = rd_q + 4'h1;
            if (bus.push && !full && !do_pop)
                cnt_d = cnt_q + 5'h01;
            else if (do_pop && !bus.push)
                cnt_d = cnt_q - 5'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 16; i++)
                mem_q[i] <= 8'h00;
            wr_q  <= 4'h0;
            rd_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign bus.head  = mem_q[rd_q];
    assign bus.count = cnt_q;
endmodule : rrm_byte_buffer

// ---- rtl/rrm_cfg.svh ----
// register map, field positions, reset values and timing counts
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
`ifndef RRM_CFG_SVH
`define RRM_CFG_SVH

`define RRM_OFF_CTRL1  5'h00
`define RRM_OFF_CTRL4  5'h04
`define RRM_OFF_CTRL5  5'h08
`define RRM_OFF_CTRL6  5'h0C
`define RRM_OFF_TXDATA 5'h10
`define RRM_OFF_RXDATA 5'h14
`define RRM_OFF_STATUS 5'h18

`define RRM_C1_OPL  0
`define RRM_C1_OPH  1
`define RRM_C1_IRL  2
`define RRM_C1_IRH  3
`define RRM_C1_PAT  4
`define RRM_C1_TRN  5
`define RRM_C4_ASK  0
`define RRM_C4_LIMIT_SCALE_SEL 1
`define RRM_C6_BR   6

`define RRM_CTRL1_RST 6'h00
`define RRM_CTRL4_RST 2'h0
`define RRM_CTRL5_RST 6'h00
`define RRM_CTRL6_RST 8'h00

`define RRM_DEPTH 5'h10
`define RRM_THR_0  5'h00
`define RRM_THR_4  5'h04
`define RRM_THR_8  5'h08
`define RRM_THR_12 5'h0C

`define RRM_CLK_NS      10
`define RRM_HALF_BIT_NS 25000

`endif

// ---- rtl/rrm_pkg.sv ----
// types shared by the bit mapper and its byte buffer
// assumes nothing of its surroundings
package rrm_pkg;
    typedef logic [7:0] rrm_byte_t;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_START  = 3'b010,
        ST_ACTIVE = 3'b100
    } rrm_state_e;
    typedef enum logic [2:0] {
        R_C1, R_C4, R_C5, R_C6, R_TX, R_RX, R_ST, R_NONE
    } rrm_reg_e;
endpackage : rrm_pkg
